// File: rtl/tasc_scan_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "tasc_defines.vh"

module tasc_scan_ctrl #(
  parameter CONV_DIV = `TASC_CONV_DIV
) (
  input  wire        I_CORE_CLK,
  input  wire        I_RESET_N,
  input  wire        I_SPI_SCLK,
  input  wire        I_SPI_SS_N,
  input  wire        I_SPI_MOSI,
  output wire        O_SPI_MISO,
  output wire        O_SPI_MISO_OE_N,
  input  wire        I_PEN_DOWN,
  input  wire [11:0] I_ADC_CODE,
  input  wire [3:0]  I_AUTO_SCAN_SEL,
  output reg  [3:0]  O_ADC_CHANNEL,
  output wire        O_ADC_POWER_DOWN,
  output wire        O_X_DRV_EN,
  output wire        O_Y_DRV_EN
);

  // ========================================================================
  // helpers
  // ========================================================================
  // channel set converted by each scan mode, bit n is channel index n
  function [8:0] mode_mask;
    input [3:0] m;
    input [3:0] sel;
    begin
      case (m)
        `TASC_M_XY:   mode_mask = 9'h003;
        `TASC_M_XYZ:  mode_mask = 9'h00F;
        `TASC_M_X:    mode_mask = 9'h001;
        `TASC_M_Y:    mode_mask = 9'h002;
        `TASC_M_Z:    mode_mask = 9'h00C;
        `TASC_M_BAT:  mode_mask = 9'h010;
        `TASC_M_AUXILIARY_INPUT_TWO: mode_mask = 9'h040;
        `TASC_M_AUXILIARY_INPUT_ONE: mode_mask = 9'h020;
        `TASC_M_AUTO: mode_mask = {sel, 5'h00};
        `TASC_M_T1:   mode_mask = 9'h080;
        `TASC_M_PORT: mode_mask = 9'h070;
        `TASC_M_T2:   mode_mask = 9'h100;
        default:      mode_mask = 9'h000;
      endcase
    end
  endfunction

  // lowest pending channel is converted first
  function [3:0] first_ch;
    input [8:0] mask;
    integer k;
    begin
      first_ch = 4'h0;
      for (k = `TASC_NUM_CH - 1; k >= 0; k = k - 1) begin
        if (mask[k]) begin
          first_ch = k[3:0];
        end
      end
    end
  endfunction

  // ========================================================================
  // state
  // ========================================================================
  reg         pacing_q;
  reg         stop_q;
  reg  [3:0]  mode_q;
  reg  [1:0]  conversion_resolution_q;
  reg  [8:0]  pend_q;
  reg  [3:0]  cur_q;
  reg         run_q;
  reg  [11:0] res_q [0:`TASC_NUM_CH-1];
  reg         sclk_q;
  reg  [5:0]  bit_q;
  reg  [15:0] in_sr_q;
  reg  [15:0] cmd_q;
  reg  [15:0] out_sr_q;
  reg         wr_ctrl;
  reg  [15:0] wr_data;
  reg  [15:0] rd_word;
  wire        conv_busy;
  wire        conv_done;
  wire [11:0] conv_res;
  wire        sclk_rise = I_SPI_SCLK & ~sclk_q;
  wire        sclk_fall = ~I_SPI_SCLK & sclk_q;
  wire [15:0] shifted   = {in_sr_q[14:0], I_SPI_MOSI};
  wire [3:0]  cmd_page  = cmd_q[`TASC_CMD_PAGE_MSB:`TASC_CMD_PAGE_LSB];
  wire [5:0]  cmd_addr  = cmd_q[`TASC_CMD_ADDR_MSB:`TASC_CMD_ADDR_LSB];
  wire        touch_md  = (mode_q >= `TASC_M_XY) && (mode_q <= `TASC_M_Z);
  wire        go_ok     = !pacing_q || !touch_md || I_PEN_DOWN;
  wire [8:0]  pend_left = pend_q & ~(9'h001 << cur_q);
  wire        repeat_md = ((mode_q == `TASC_M_XY || mode_q == `TASC_M_XYZ)
                          && I_PEN_DOWN) || (mode_q == `TASC_M_AUTO);
  wire        launch    = !run_q && (pend_q != 9'h000) && !stop_q && go_ok
                          && !wr_ctrl;
  integer     i;

  // ========================================================================
  // serial register port, mode 0: sample on rise, shift out on fall
  // ========================================================================
  always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sclk_q   <= 1'b0;
      bit_q    <= 6'h00;
      in_sr_q  <= 16'h0000;
      cmd_q    <= 16'h0000;
      out_sr_q <= 16'h0000;
      wr_ctrl  <= 1'b0;
      wr_data  <= 16'h0000;
    end else begin
      sclk_q  <= I_SPI_SCLK;
      wr_ctrl <= 1'b0;
      if (I_SPI_SS_N) begin
        bit_q <= 6'h00;              // frame end discards partial words
      end else if (sclk_rise && bit_q < 6'h20) begin
        in_sr_q <= shifted;
        bit_q   <= bit_q + 6'h01;
        if (bit_q == 6'h0F) begin
          cmd_q <= shifted;
        end
        // only the control word is writable; result page ignores writes
        if (bit_q == 6'h1F && !cmd_q[`TASC_CMD_RD_BIT]
            && cmd_page == `TASC_PAGE_CTRL
            && cmd_addr == `TASC_CTRL_OFFSET) begin
          wr_ctrl <= 1'b1;
          wr_data <= shifted;
        end
      end else if (sclk_fall) begin
        if (bit_q == 6'h10 && cmd_q[`TASC_CMD_RD_BIT]) begin
          out_sr_q <= rd_word;
        end else begin
          out_sr_q <= {out_sr_q[14:0], 1'b0};
        end
      end
    end
  end

  // read data mux; the write view of bits 15 and 14 is not read back
  always @* begin
    rd_word = 16'h0000;
    if (cmd_page == `TASC_PAGE_CTRL && cmd_addr == `TASC_CTRL_OFFSET) begin
      // busy covers both the sequencer slot and the converter itself
      rd_word = {I_PEN_DOWN, ~(run_q | conv_busy),
                 mode_q, conversion_resolution_q, 8'h00};
    end else if (cmd_page == `TASC_PAGE_DATA
                 && cmd_addr < `TASC_NUM_CH) begin
      rd_word = {4'h0, res_q[cmd_addr[3:0]]};
    end
  end

  assign O_SPI_MISO      = out_sr_q[15];
  assign O_SPI_MISO_OE_N = I_SPI_SS_N;

  // ========================================================================
  // control register and scan sequencer
  // ========================================================================
  // a write always wins over a finishing conversion so a stop is never lost
  always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pacing_q      <= 1'b0;
      stop_q        <= 1'b0;
      mode_q        <= `TASC_M_NONE;
      conversion_resolution_q       <= `TASC_RES_12A;
      pend_q        <= 9'h000;
      cur_q         <= 4'h0;
      run_q         <= 1'b0;
      O_ADC_CHANNEL <= 4'h0;
      for (i = 0; i < `TASC_NUM_CH; i = i + 1) begin
        res_q[i] <= 12'h000;
      end
    end else if (wr_ctrl) begin
      pacing_q <= wr_data[`TASC_PEN_BIT];
      stop_q   <= wr_data[`TASC_STOP_BIT];
      mode_q   <= wr_data[`TASC_MODE_MSB:`TASC_MODE_LSB];
      conversion_resolution_q  <= wr_data[`TASC_RES_MSB:`TASC_RES_LSB];
      run_q    <= 1'b0;              // rewrite restarts any scan unless it sets the stop bit
      if (wr_data[`TASC_STOP_BIT]) begin
        pend_q <= 9'h000;
      end else begin
        pend_q <= mode_mask(wr_data[`TASC_MODE_MSB:`TASC_MODE_LSB],
                            I_AUTO_SCAN_SEL);
      end
    end else if (launch) begin
      run_q         <= 1'b1;
      cur_q         <= first_ch(pend_q);
      O_ADC_CHANNEL <= first_ch(pend_q);
    end else if (run_q && conv_done) begin
      run_q         <= 1'b0;
      res_q[cur_q]  <= conv_res;
      // continuous modes reload; pen lift ends touch scans
      if (pend_left == 9'h000 && repeat_md) begin
        pend_q <= mode_mask(mode_q, I_AUTO_SCAN_SEL);
      end else begin
        pend_q <= pend_left;
      end
    end
  end

  // ========================================================================
  // converter and panel drivers
  // ========================================================================
  tasc_sar_conv #(
    .DIV      (CONV_DIV)
  ) u_conv (
    .i_clk    (I_CORE_CLK),
    .i_rst_n  (I_RESET_N),
    .i_start  (launch),
    .i_abort  (wr_ctrl),
    .i_conversion_resolution  (conversion_resolution_q),
    .i_code   (I_ADC_CODE),
    .o_busy   (conv_busy),
    .o_done   (conv_done),
    .o_result (conv_res)
  );

  assign O_ADC_POWER_DOWN = stop_q;
  // drivers follow the axis under conversion or a driver-only mode
  assign O_X_DRV_EN = (!stop_q && mode_q == `TASC_M_XDRV)
                      || (run_q && cur_q == `TASC_CH_X);
  assign O_Y_DRV_EN = (!stop_q && (mode_q == `TASC_M_YDRV
                      || mode_q == `TASC_M_YDRV_ALT))
                      || (run_q && cur_q == `TASC_CH_Y);

endmodule // tasc_scan_ctrl
`default_nettype wire

// File: rtl/tasc_defines.vh
`ifndef TASC_DEFINES_VH
`define TASC_DEFINES_VH

// ==========================================================================
// serial frame: command word then data word
// ==========================================================================
`define TASC_CMD_RD_BIT     15
`define TASC_CMD_PAGE_MSB   14
`define TASC_CMD_PAGE_LSB   11
`define TASC_CMD_ADDR_MSB   10
`define TASC_CMD_ADDR_LSB   5
`define TASC_PAGE_DATA      4'h0
`define TASC_PAGE_CTRL      4'h1
`define TASC_CTRL_OFFSET    6'h00

// ==========================================================================
// control register fields
// ==========================================================================
`define TASC_PEN_BIT        15
`define TASC_STOP_BIT       14
`define TASC_MODE_MSB       13
`define TASC_MODE_LSB       10
`define TASC_RES_MSB        9
`define TASC_RES_LSB        8

// ==========================================================================
// scan mode codes
// ==========================================================================
`define TASC_M_NONE         4'h0
`define TASC_M_XY           4'h1
`define TASC_M_XYZ          4'h2
`define TASC_M_X            4'h3
`define TASC_M_Y            4'h4
`define TASC_M_Z            4'h5
`define TASC_M_BAT          4'h6
`define TASC_M_AUXILIARY_INPUT_TWO         4'h7
`define TASC_M_AUXILIARY_INPUT_ONE         4'h8
`define TASC_M_AUTO         4'h9
`define TASC_M_T1           4'hA
`define TASC_M_PORT         4'hB
`define TASC_M_T2           4'hC
`define TASC_M_XDRV         4'hD
`define TASC_M_YDRV_ALT     4'hE
`define TASC_M_YDRV         4'hF

// ==========================================================================
// resolution codes and result channel indices (also data page offsets)
// ==========================================================================
`define TASC_RES_12A        2'h0
`define TASC_RES_8          2'h1
`define TASC_RES_10         2'h2
`define TASC_CH_X           4'h0
`define TASC_CH_Y           4'h1
`define TASC_CH_Z1          4'h2
`define TASC_CH_Z2          4'h3
`define TASC_CH_BAT         4'h4
`define TASC_CH_AUXILIARY_INPUT_ONE        4'h5
`define TASC_CH_AUXILIARY_INPUT_TWO        4'h6
`define TASC_CH_T1          4'h7
`define TASC_CH_T2          4'h8
`define TASC_NUM_CH         9
`define TASC_CONV_DIV       4
`define TASC_CONV_EXTRA     5'h04

`endif

// File: rtl/tasc_sar_conv.v
`timescale 1ns/1ps
`default_nettype none
`include "tasc_defines.vh"

module tasc_sar_conv #(
  parameter DIV = `TASC_CONV_DIV
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_start,
  input  wire        i_abort,
  input  wire [1:0]  i_conversion_resolution,
  input  wire [11:0] i_code,
  output wire        o_busy,
  output reg         o_done,
  output reg  [11:0] o_result
);

  reg  [7:0]  div_q;
  reg  [4:0]  cnt_q;
  reg         busy_q;
  reg  [1:0]  res_q;
  wire        tick = (div_q == 8'h00);

  // ========================================================================
  // internal conversion clock enable from a divider
  // ========================================================================
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= 8'h00;
    end else if (!busy_q || tick) begin
      div_q <= DIV[7:0] - 8'h01;
    end else begin
      div_q <= div_q - 8'h01;
    end
  end

  // ========================================================================
  // conversion takes resolution plus fixed overhead ticks
  // ========================================================================
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q   <= 1'b0;
      cnt_q    <= 5'h00;
      res_q    <= 2'h0;
      o_done   <= 1'b0;
      o_result <= 12'h000;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        busy_q <= 1'b0;
      end else if (i_start) begin
        busy_q <= 1'b1;
        res_q  <= i_conversion_resolution;
        case (i_conversion_resolution)
          `TASC_RES_8:  cnt_q <= 5'h08 + `TASC_CONV_EXTRA;
          `TASC_RES_10: cnt_q <= 5'h0A + `TASC_CONV_EXTRA;
          default:      cnt_q <= 5'h0C + `TASC_CONV_EXTRA;
        endcase
      end else if (busy_q && tick) begin
        if (cnt_q == 5'h01) begin
          busy_q <= 1'b0;
          o_done <= 1'b1;
          // right-justify the kept bits, upper bits zero
          case (res_q)
            `TASC_RES_8:  o_result <= {4'h0, i_code[11:4]};
            `TASC_RES_10: o_result <= {2'h0, i_code[11:2]};
            default:      o_result <= i_code;
          endcase
        end
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end

  assign o_busy = busy_q;

endmodule // tasc_sar_conv
`default_nettype wire

// File: testbench/tasc_scan_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checks on the scan controller
module tasc_chk #(
  parameter CONV_DIV = 4
) (
  input wire logic       I_CORE_CLK,
  input wire logic       I_RESET_N,
  input wire logic       I_SPI_SS_N,
  input wire logic       O_SPI_MISO_OE_N,
  input wire logic [3:0] O_ADC_CHANNEL,
  input wire logic       O_ADC_POWER_DOWN,
  input wire logic       O_X_DRV_EN,
  input wire logic       O_Y_DRV_EN
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);
  // nothing launched or driven right after reset
  rst_idle_a: assert property (
    $rose(I_RESET_N) |-> O_ADC_CHANNEL == 4'h0 && !O_ADC_POWER_DOWN
    && !O_X_DRV_EN && !O_Y_DRV_EN)
    else $error("outputs not idle after reset");
  pd_freeze_a: assert property (
    O_ADC_POWER_DOWN && $past(O_ADC_POWER_DOWN)
    && $past(O_ADC_POWER_DOWN, 2) |-> $stable(O_ADC_CHANNEL))
    else $error("conversion launched while powered down");
  pd_hold_a: assert property (
    $rose(O_ADC_POWER_DOWN) |=> $stable(O_ADC_CHANNEL)[*4])
    else $error("launch after stop");
  // both axes never driven together
  drv_excl_a: assert property (
    !(O_X_DRV_EN && O_Y_DRV_EN))
    else $error("x and y drivers both on");
  chan_range_a: assert property (
    O_ADC_CHANNEL <= 4'h8)
    else $error("channel index out of range");
  x_conv_drv_a: assert property (
    $changed(O_ADC_CHANNEL) && O_ADC_CHANNEL == 4'h0 |-> ##[0:2] O_X_DRV_EN)
    else $error("x conversion without x drivers");
  y_conv_drv_a: assert property (
    $changed(O_ADC_CHANNEL) && O_ADC_CHANNEL == 4'h1 |-> ##[0:2] O_Y_DRV_EN)
    else $error("y conversion without y drivers");
  oe_follow_a: assert property (
    O_SPI_MISO_OE_N == I_SPI_SS_N)
    else $error("miso enable not tied to select");
endmodule // tasc_chk
bind tasc_scan_ctrl tasc_chk #(.CONV_DIV(CONV_DIV)) chk_u (
  .I_CORE_CLK(I_CORE_CLK),
  .I_RESET_N(I_RESET_N),
  .I_SPI_SS_N(I_SPI_SS_N),
  .O_SPI_MISO_OE_N(O_SPI_MISO_OE_N),
  .O_ADC_CHANNEL(O_ADC_CHANNEL),
  .O_ADC_POWER_DOWN(O_ADC_POWER_DOWN),
  .O_X_DRV_EN(O_X_DRV_EN),
  .O_Y_DRV_EN(O_Y_DRV_EN)
);
`default_nettype wire

// File: testbench/tasc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// serial host: one 32-bit frame per go pulse
module tasc_host (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [31:0] i_word,
  input  wire logic        i_miso,
  output var  logic        o_sclk,
  output var  logic        o_ss_n,
  output var  logic        o_mosi,
  output var  logic        o_done,
  output var  logic [15:0] o_rdata
);
  // sclk parked low; mosi toggles while deselected so it is never stale
  initial begin
    o_sclk = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
    o_done = 1'b0;
    o_rdata = 16'h0000;
    forever begin
      @(posedge i_clk);
      o_done <= 1'b0;
      o_mosi <= ~o_mosi;
      if (i_go) begin
        o_ss_n <= 1'b0;
        for (int k = 31; k >= 0; k--) begin
          @(posedge i_clk);
          o_mosi <= i_word[k];
          @(posedge i_clk);
          o_sclk <= 1'b1;
          if (k < 16) o_rdata[k] <= i_miso;
          repeat (2) @(posedge i_clk);
          o_sclk <= 1'b0;
          // long low phase leaves room for the miso update
          repeat (3) @(posedge i_clk);
        end
        o_ss_n <= 1'b1;
        o_done <= 1'b1;
      end
    end
  end
endmodule // tasc_host
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// scan controller bench
module testbench;
  logic        clk, rst_n, pen, go, sclk, ss_n, mosi, miso, done;
  logic        pd, xdrv, ydrv;
  logic [11:0] code;
  logic [3:0]  sel, chan;
  logic [31:0] word, seed;
  logic [15:0] rdata, rd;
  logic [15:0] res_q [9];
  int          n_fail, tests_run;

  tasc_scan_ctrl #(.CONV_DIV(1)) dut_u (
    .I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_SPI_SCLK(sclk),
    .I_SPI_SS_N(ss_n), .I_SPI_MOSI(mosi), .O_SPI_MISO(miso),
    .O_SPI_MISO_OE_N(), .I_PEN_DOWN(pen), .I_ADC_CODE(code),
    .I_AUTO_SCAN_SEL(sel), .O_ADC_CHANNEL(chan),
    .O_ADC_POWER_DOWN(pd), .O_X_DRV_EN(xdrv), .O_Y_DRV_EN(ydrv)
  );
  tasc_host host_u (
    .i_clk(clk), .i_go(go), .i_word(word), .i_miso(miso),
    .o_sclk(sclk), .o_ss_n(ss_n), .o_mosi(mosi), .o_done(done),
    .o_rdata(rdata)
  );

  // ==========================================================
  // expectations
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [15:0] rj(input logic [11:0] c,
                                     input logic [1:0]  r);
    case (r)
      2'h1: return {8'h00, c[11:4]};
      2'h2: return {6'h00, c[11:2]};
      default: return {4'h0, c};
    endcase
  endfunction
  // last channel launched by a one-pass scan, the highest set bit
  function automatic logic [3:0] lastch(input logic [8:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < 9; k++) if (s[k]) r = k[3:0];
    return r;
  endfunction
  // result registers written by each mode, bit n = channel n
  function automatic logic [8:0] chset(input logic [3:0] m,
                                       input logic [3:0] s);
    case (m)
      4'h1: return 9'h003;
      4'h2: return 9'h00f;
      4'h3: return 9'h001;
      4'h4: return 9'h002;
      4'h5: return 9'h00c;
      4'h6: return 9'h010;
      4'h7: return 9'h040;
      4'h8: return 9'h020;
      4'h9: return {s, 5'h00};
      4'ha: return 9'h080;
      4'hb: return 9'h070;
      4'hc: return 9'h100;
      default: return 9'h000;
    endcase
  endfunction

  // ==========================================================
  // frame, compare and closing tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [31:0] w);
    int k;
    word <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (done !== 1'b1 && k < 400);
    if (k >= 400) n_fail++;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd_chk(input logic [15:0] cmd, input logic [15:0] exp);
    frame({cmd, 16'h0000});
    check(rdata, exp);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, well beyond the planned frames
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  // ==========================================================
  // main sequence: every scan mode once, then a stopped scan
  initial begin
    logic [3:0] m, c;
    logic [1:0] r;
    logic [8:0] mask;
    logic       stp, pace, cont;
    rst_n = 1'b0;
    pen = 1'b0;
    go = 1'b0;
    word = 32'h0000_0000;
    code = 12'h000;
    sel = 4'h0;
    seed = 32'he421_bf59;
    n_fail = 0;
    tests_run = 0;
    for (c = 0; c < 9; c++) res_q[c] = 16'h0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(16'h8800, 16'h4000);
    for (c = 0; c < 9; c++)
      rd_chk({5'h10, 2'h0, c, 5'h00}, 16'h0000);
    for (int i = 0; i < 17; i++) begin
      seed = xs(seed);
      m = (i == 16) ? 4'h2 : i[3:0];
      stp = (i == 16);
      pace = seed[0];
      r = seed[19:18];
      pen <= (i == 16) | seed[1];
      sel <= seed[5:2];
      code <= seed[17:6];
      @(posedge clk);
      // device pacing holds touch scans until the pen is down
      mask = (stp | (pace & ~pen & m >= 4'h1 & m <= 4'h5)) ? 9'h000
             : chset(m, sel);
      cont = mask != 0 && ((m == 4'h1 || m == 4'h2) && pen || m == 4'h9);
      // stop case: start a pen-down full scan so the stop must abort it
      if (stp) begin
        frame({16'h0800, 2'b00, m, r, 8'h00});
        for (c = 0; c < 4; c++) res_q[c] = rj(code, r);
      end
      frame({16'h0800, pace, stp, m, r, 8'h00});
      check({15'h0000, pd}, {15'h0000, stp});
      if (m == 4'h0 || m >= 4'hd) begin
        check({15'h0000, xdrv}, {15'h0000, m == 4'hd});
        check({15'h0000, ydrv}, {15'h0000, m >= 4'he});
      end
      frame(32'h8800_0000);
      rd = rdata;
      // a repeating scan may legitimately read busy
      if (cont) rd[14] = 1'b1;
      check(rd, {pen, 1'b1, m, r, 8'h00});
      // a one-pass scan ends on its highest channel
      if (mask != 9'h000 && !cont)
        check({12'h000, chan}, {12'h000, lastch(mask)});
      for (c = 0; c < 9; c++) if (mask[c]) res_q[c] = rj(code, r);
      for (c = 0; c < 9; c++)
        rd_chk({5'h10, 2'h0, c, 5'h00}, res_q[c]);
      // park in no-scan before the code input moves
      frame(32'h0800_0000);
      $display("test %0d mode %h done", i, m);
    end
    stop_test();
  end
endmodule // testbench
`default_nettype wire
